// ===== design/fwdc_cache.sv
// Four-way set-associative cache with APB control registers
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "fwdc_defines.svh"

// What this block does
// - Four ways of 256 sixteen-byte lines
// - Address splits into tag, index, offset
// - Lines are 16-byte aligned blocks
// - Per-set valid vector, one bit per way
// - Cacheable read miss fetches whole line
// - Caching needs enable, page bit, external enable
// - I/O accesses never allocate
// - Only read misses start fills
// - Write-through hit updates cache and bus
// - Write-back hit updates only the line
// - Three pseudo-LRU bits per set
// - LRU updated on hits and fills
// - Flush or reset clears all valid bits
// - Fill picks invalid way, else LRU victim
// - Partly filled lines stay invalid
// - Bus invalidation clears matching line
// - Both off: static RAM, nothing active
// - Fills off, write-through on: invalidations active
// - Both on: everything active
// - Fills disabled still serve hits
// - Write-through off: no write, no invalidation
// - Both off: only misses reach bus, read misses as single uncached words
// - New lookup accepted every cycle the controller is idle
module fwdc_cache (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [31:0] reqAddr,
  input wire logic [31:0] reqWdata,
  input wire logic [3:0] reqByteEn,
  input wire logic reqPageCacheable,
  input wire logic reqIo,
  output logic reqReady,
  output logic respValid,
  output logic [31:0] respRdata,
  output logic busReqValid,
  output logic busReqWrite,
  output logic busReqLine,
  output logic [31:0] busReqAddr,
  output logic [31:0] busWdata,
  output logic [3:0] busByteEn,
  input wire logic busReqAck,
  input wire logic busRdValid,
  input wire logic [31:0] busRdata,
  input wire logic busRdLast,
  input wire logic busCacheEnable,
  input wire logic invValid,
  input wire logic [31:0] invAddr
);
  import fwdc_pkg::*;

  // ==========================================================
  // Helper functions
  // One-hot hit vector to way number
  function automatic logic [1:0] fwdcEnc(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    if (v[1]) r = 2'h1;
    if (v[2]) r = 2'h2;
    if (v[3]) r = 2'h3;
    return r;
  endfunction

  // Lowest invalid way
  function automatic logic [1:0] fwdcFirstFree(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h3;
    if (!v[2]) r = 2'h2;
    if (!v[1]) r = 2'h1;
    if (!v[0]) r = 2'h0;
    return r;
  endfunction

  // Tree walk: bit0 picks the pair, bit1/bit2 the way in it
  function automatic logic [1:0] fwdcVictim(input logic [2:0] l);
    return l[0] ? {1'b1, l[2]} : {1'b0, l[1]};
  endfunction

  // Point the tree away from the way just used
  function automatic logic [2:0] fwdcTouch(input logic [2:0] l, input logic [1:0] w);
    logic [2:0] r;
    r = l;
    case (w)
      2'h0: r = {l[2], 2'b11};
      2'h1: r = {l[2], 2'b01};
      2'h2: r = {1'b1, l[1], 1'b0};
      default: r = {1'b0, l[1], 1'b0};
    endcase
    return r;
  endfunction

  // Word select within a line
  function automatic logic [31:0] fwdcWord(input fwdc_line_t ln, input logic [1:0] sel);
    return ln[{sel, 5'h0} +: 32];
  endfunction

  // Byte-enable merge of one word into a line
  function automatic fwdc_line_t fwdcMerge(input fwdc_line_t ln, input logic [1:0] sel,
                                           input logic [31:0] d, input logic [3:0] be);
    fwdc_line_t r;
    r = ln;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[{sel, 5'h0} + 7'(8 * b) +: 8] = d[8 * b +: 8];
    end
    return r;
  endfunction

  // ==========================================================
  // Storage arrays
  fwdc_line_t dataMem [`FWDC_WAYS][`FWDC_SETS]; // Line data per way
  fwdc_tag_t tagMem [`FWDC_WAYS][`FWDC_SETS]; // Tags per way
  logic [3:0] validMem [`FWDC_SETS]; // Valid vector per set
  logic [3:0] dirtyMem [`FWDC_SETS]; // Modified lines, write-back only
  logic [2:0] lruMem [`FWDC_SETS]; // Pseudo-LRU tree per set

  fwdc_state_s s; // Registered state
  fwdc_state_s next_s; // Next state

  // ==========================================================
  // Lookup of the incoming request
  fwdc_idx_t lkIdx; // Set index of request
  fwdc_tag_t lkTag; // Tag of request
  logic [3:0] lkHitVec; // Ways that match
  logic lkHit; // Any way matches
  logic [1:0] lkWay; // Matching way
  logic [1:0] lkVictim; // Way a fill would take
  logic modeCe; // Fills enabled
  logic modeWt; // Write-through and invalidation enabled
  logic modeWb; // Write-back policy active
  fwdc_idx_t invIdx; // Set of invalidation address
  logic [3:0] invMask; // Ways hit by invalidation
  logic invEn; // Invalidation takes effect
  fwdc_idx_t sIdx; // Set of saved request

  always_comb begin
    modeCe = s.machineControlWord[`FWDC_MCW_CE];
    modeWt = s.machineControlWord[`FWDC_MCW_WT];
    modeWb = modeCe & modeWt & s.machineControlWord[`FWDC_MCW_WB];
    lkIdx = reqAddr[11:4];
    lkTag = reqAddr[31:12];
    sIdx = s.addr[11:4];
    for (int w = 0; w < 4; w++) begin
      lkHitVec[w] = validMem[lkIdx][w] && (tagMem[w][lkIdx] == lkTag);
    end
    lkHit = |lkHitVec;
    lkWay = fwdcEnc(lkHitVec);
    // Free way first, tree only when the set is full
    lkVictim = (&validMem[lkIdx]) ? fwdcVictim(lruMem[lkIdx]) : fwdcFirstFree(validMem[lkIdx]);
    invIdx = invAddr[11:4];
    for (int w = 0; w < 4; w++) begin
      invMask[w] = validMem[invIdx][w] && (tagMem[w][invIdx] == invAddr[31:12]);
    end
    invEn = invValid && modeWt;
  end

  // ==========================================================
  // Array write requests built by the controller
  logic dWrEn; // Write a line, tag only with tWrEn
  logic [1:0] dWrWay;
  fwdc_idx_t dWrIdx;
  fwdc_line_t dWrLine;
  logic tWrEn; // Tag update, fills only
  logic vSetEn; // Mark a way valid after a full fill
  logic lruEn;
  fwdc_idx_t lruIdx;
  logic [2:0] lruVal;
  logic dirtySet; // Write hit under write-back
  logic kenNow; // Fill still cacheable this cycle
  fwdc_line_t fillLine; // Fill buffer with current beat

  // ==========================================================
  // Controller and APB slave
  always_comb begin
    next_s = s;
    next_s.respValid = 1'b0;
    next_s.flushPulse = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    dWrEn = 1'b0;
    dWrWay = lkWay;
    dWrIdx = lkIdx;
    dWrLine = dataMem[lkWay][lkIdx];
    tWrEn = 1'b0;
    vSetEn = 1'b0;
    lruEn = 1'b0;
    lruIdx = lkIdx;
    lruVal = lruMem[lkIdx];
    dirtySet = 1'b0;
    fillLine = fwdcMerge(s.fbuf, s.cnt, busRdata, 4'hf);
    kenNow = s.kenOk && (s.cnt != 2'h0 || busCacheEnable);
    // A line invalidated while in flight must not land valid
    if (invEn && s.st == ST_RDWAIT && invAddr[31:4] == s.addr[31:4]) begin
      kenNow = 1'b0;
      next_s.kenOk = 1'b0;
    end

    // APB: answer one cycle into the access phase
    if (psel && penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0;
      case (paddr)
        `FWDC_OFS_MCW: next_s.prdata = {29'h0, s.machineControlWord};
        `FWDC_OFS_STATUS: next_s.prdata = {26'h0, s.cand, s.st, ~s.reqReady};
        `FWDC_OFS_HITS: next_s.prdata = s.hits;
        `FWDC_OFS_MISSES: next_s.prdata = s.misses;
        default: next_s.pslverr = 1'b1; // Unmapped offset
      endcase
    end
    // A write lands only at the edge that completes the access
    if (psel && penable && pwrite && s.pready && paddr == `FWDC_OFS_MCW) begin
      next_s.machineControlWord = pwdata[2:0];
      next_s.flushPulse = pwdata[`FWDC_MCW_FLUSH];
    end

    case (s.st)
      ST_IDLE: begin
        // Lookup every cycle while idle
        if (reqValid) begin
          next_s.addr = reqAddr;
          next_s.wdata = reqWdata;
          next_s.be = reqByteEn;
          if (lkHit) begin
            next_s.hits = s.hits + 32'h1;
            lruEn = 1'b1;
            lruVal = fwdcTouch(lruMem[lkIdx], lkWay);
          end else begin
            next_s.misses = s.misses + 32'h1;
          end
          if (reqWrite) begin
            if (lkHit) begin
              dWrEn = 1'b1;
              dWrLine = fwdcMerge(dataMem[lkWay][lkIdx], reqAddr[3:2], reqWdata, reqByteEn);
              dirtySet = modeWb;
            end
            // Misses always go out; hits only under write-through
            if (!lkHit || (modeWt && !modeWb)) begin
              next_s.st = ST_WRITE;
              next_s.busReqValid = 1'b1;
              next_s.busReqWrite = 1'b1;
              next_s.busReqLine = 1'b0;
              next_s.busReqAddr = reqAddr;
              next_s.busWdata = reqWdata;
              next_s.busByteEn = reqByteEn;
            end else begin
              next_s.respValid = 1'b1;
            end
          end else if (lkHit) begin
            next_s.respValid = 1'b1;
            next_s.respRdata = fwdcWord(dataMem[lkWay][lkIdx], reqAddr[3:2]);
          end else begin
            // Read miss: line fetch only if allowed to allocate
            next_s.cand = modeCe && reqPageCacheable && !reqIo;
            next_s.kenOk = next_s.cand;
            next_s.way = lkVictim;
            next_s.cnt = 2'h0;
            next_s.busReqValid = 1'b1;
            next_s.busReqWrite = 1'b0;
            next_s.busByteEn = 4'hf;
            if (next_s.cand && dirtyMem[lkIdx][lkVictim] && validMem[lkIdx][lkVictim]) begin
              // Dirty victim is written out before it is replaced
              next_s.st = ST_EVICT;
              next_s.busReqWrite = 1'b1;
              next_s.busReqLine = 1'b0;
              next_s.busReqAddr = {tagMem[lkVictim][lkIdx], lkIdx, 4'h0};
              next_s.busWdata = fwdcWord(dataMem[lkVictim][lkIdx], 2'h0);
            end else begin
              next_s.st = ST_RDWAIT;
              next_s.busReqLine = next_s.cand;
              next_s.busReqAddr = next_s.cand ? {reqAddr[31:4], 4'h0} : reqAddr;
            end
          end
        end
      end
      ST_WRITE: begin
        // Hold the write until the bus side takes it
        if (busReqAck) begin
          next_s.busReqValid = 1'b0;
          next_s.respValid = 1'b1;
          next_s.st = ST_IDLE;
        end
      end
      ST_EVICT: begin
        if (busReqAck) begin
          if (s.cnt == 2'h3) begin
            next_s.cnt = 2'h0;
            next_s.st = ST_RDWAIT;
            next_s.busReqWrite = 1'b0;
            next_s.busReqLine = 1'b1;
            next_s.busReqAddr = {s.addr[31:4], 4'h0};
          end else begin
            next_s.cnt = s.cnt + 2'h1;
            next_s.busReqAddr = {tagMem[s.way][sIdx], sIdx, next_s.cnt, 2'h0};
            next_s.busWdata = fwdcWord(dataMem[s.way][sIdx], next_s.cnt);
          end
        end
      end
      ST_RDWAIT: begin
        if (busReqAck) next_s.busReqValid = 1'b0;
        if (busRdValid) begin
          // Beats arrive in ascending word order
          next_s.kenOk = kenNow;
          next_s.fbuf = fillLine;
          next_s.cnt = s.cnt + 2'h1;
          if (!s.busReqLine || s.cnt == s.addr[3:2]) next_s.respRdata = busRdata;
          if (busRdLast) begin
            next_s.respValid = 1'b1;
            next_s.st = ST_IDLE;
            next_s.cand = 1'b0;
            // Only a complete, still-cacheable line is installed
            if (s.busReqLine && kenNow && s.cnt == 2'h3) begin
              dWrEn = 1'b1;
              tWrEn = 1'b1;
              vSetEn = 1'b1;
              dWrWay = s.way;
              dWrIdx = sIdx;
              dWrLine = fillLine;
              lruEn = 1'b1;
              lruIdx = sIdx;
              lruVal = fwdcTouch(lruMem[sIdx], s.way);
            end
          end
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
    next_s.reqReady = (next_s.st == ST_IDLE);
  end

  // ==========================================================
  // State register; clock enable freezes everything
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.reqReady <= 1'b1;
      s.machineControlWord <= `FWDC_MCW_RST;
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Valid, dirty and LRU bits; reset clears them
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `FWDC_SETS; i++) begin
        validMem[i] <= 4'h0;
        dirtyMem[i] <= 4'h0;
        lruMem[i] <= 3'h0;
      end
    end else if (clkEn) begin
      if (s.flushPulse) begin
        // Flush drops every line, modified data included
        for (int i = 0; i < `FWDC_SETS; i++) begin
          validMem[i] <= 4'h0;
          dirtyMem[i] <= 4'h0;
        end
      end else begin
        // Fill and invalidation of one set are merged
        if (vSetEn) begin
          validMem[dWrIdx] <= (validMem[dWrIdx] | (4'h1 << dWrWay))
                              & ~((invEn && invIdx == dWrIdx) ? invMask : 4'h0);
          dirtyMem[dWrIdx] <= dirtyMem[dWrIdx] & ~(4'h1 << dWrWay);
        end
        if (invEn && !(vSetEn && invIdx == dWrIdx)) begin
          validMem[invIdx] <= validMem[invIdx] & ~invMask;
        end
        if (dirtySet) dirtyMem[dWrIdx] <= dirtyMem[dWrIdx] | (4'h1 << dWrWay);
      end
      if (lruEn) lruMem[lruIdx] <= lruVal;
    end
  end

  // ==========================================================
  // Data and tag arrays; no reset, guarded by valid bits
  always_ff @(posedge clk_sys) begin
    if (clkEn && dWrEn) dataMem[dWrWay][dWrIdx] <= dWrLine;
    if (clkEn && tWrEn) tagMem[dWrWay][dWrIdx] <= s.addr[31:12];
  end

  // ==========================================================
  // Outputs straight from the state register
  assign pready = s.pready;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign reqReady = s.reqReady;
  assign respValid = s.respValid;
  assign respRdata = s.respRdata;
  assign busReqValid = s.busReqValid;
  assign busReqWrite = s.busReqWrite;
  assign busReqLine = s.busReqLine;
  assign busReqAddr = s.busReqAddr;
  assign busWdata = s.busWdata;
  assign busByteEn = s.busByteEn;
endmodule
`default_nettype wire

// ===== design/fwdc_defines.svh
// Offsets, field positions and reset values of the four-way cache
`ifndef FWDC_DEFINES_SVH
`define FWDC_DEFINES_SVH
// ==========================================================
// Register offsets (byte addresses on APB)
`define FWDC_OFS_MCW 8'h00
`define FWDC_OFS_STATUS 8'h04
`define FWDC_OFS_HITS 8'h08
`define FWDC_OFS_MISSES 8'h0c
// ==========================================================
// Machine control word fields
`define FWDC_MCW_CE 0
`define FWDC_MCW_WT 1
`define FWDC_MCW_WB 2
`define FWDC_MCW_FLUSH 3
`define FWDC_MCW_RST 3'h0
// ==========================================================
// Geometry
`define FWDC_WAYS 4
`define FWDC_SETS 256
`define FWDC_TAG_W 20
`define FWDC_IDX_W 8
`define FWDC_LINE_W 128
`endif

// ===== design/fwdc_pkg.sv
// Types shared by the four-way cache
package fwdc_pkg;
`include "fwdc_defines.svh"
  // ==========================================================
  // Controller states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WRITE = 4'h2,
    ST_RDWAIT = 4'h4,
    ST_EVICT = 4'h8
  } fwdc_state_e;
  typedef logic [`FWDC_LINE_W-1:0] fwdc_line_t;
  typedef logic [`FWDC_TAG_W-1:0] fwdc_tag_t;
  typedef logic [`FWDC_IDX_W-1:0] fwdc_idx_t;
  // ==========================================================
  // All control state of the cache
  typedef struct packed {
    fwdc_state_e st;
    logic reqReady;
    logic respValid;
    logic [31:0] respRdata;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic cand;
    logic kenOk;
    logic [1:0] way;
    logic [1:0] cnt;
    fwdc_line_t fbuf;
    logic busReqValid;
    logic busReqWrite;
    logic busReqLine;
    logic [31:0] busReqAddr;
    logic [31:0] busWdata;
    logic [3:0] busByteEn;
    logic [2:0] machineControlWord;
    logic flushPulse;
    logic [31:0] hits;
    logic [31:0] misses;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } fwdc_state_s;
endpackage

// ===== bench/fwdc_cache_sva.sv
// Port-level concurrent checks for the four-way cache
`timescale 1ns/100ps
`default_nettype none
module fwdc_cache_sva (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqIo,
  input wire logic reqReady,
  input wire logic respValid,
  input wire logic busReqValid,
  input wire logic busReqWrite,
  input wire logic busReqLine,
  input wire logic [31:0] busReqAddr,
  input wire logic [3:0] busByteEn,
  input wire logic busReqAck
);
  // ==========================================================
  // Single domain, checks are off while reset is high
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ==========================================================
  // Bus side
  line_align_a: assert property (busReqValid && busReqLine |-> busReqAddr[3:0] == 4'h0 && !busReqWrite)
    else $error("line read not aligned or marked as write");
  read_bytes_a: assert property (busReqValid && !busReqWrite |-> busByteEn == 4'hf)
    else $error("read request without all byte lanes");
  bus_hold_a: assert property (busReqValid && !busReqAck |=> busReqValid && $stable(busReqAddr) && $stable(busReqWrite))
    else $error("bus request changed before acknowledge");
  bus_busy_a: assert property (busReqValid |-> !reqReady)
    else $error("core side ready during bus transfer");
  // I/O and write lookups must not start a line read
  io_noline_a: assert property (reqValid && reqReady && reqIo |=> !(busReqValid && busReqLine) throughout (##[0:60] respValid))
    else $error("line fill for an uncacheable region");
  wr_noline_a: assert property (reqValid && reqReady && reqWrite |=> !(busReqValid && busReqLine) throughout (##[0:60] respValid))
    else $error("write lookup started a line fill");
  resp_bound_a: assert property ($fell(reqReady) |-> ##[1:400] respValid)
    else $error("lookup not answered in time");
  // ==========================================================
  // Register side
  apb_wait_a: assert property (psel && $rose(penable) |=> pready)
    else $error("register access not answered in second access cycle");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error response without ready");
endmodule
bind fwdc_cache fwdc_cache_sva u_fwdc_cache_sva (.*);
`default_nettype wire

// ===== bench/fwdc_bus_model.sv
// Behavioural bus interface and memory behind the cache
`timescale 1ns/100ps
`default_nettype none
module fwdc_bus_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic busReqValid,
  input wire logic busReqWrite,
  input wire logic busReqLine,
  input wire logic [31:0] busReqAddr,
  input wire logic [31:0] busWdata,
  input wire logic kenIn,
  output logic busReqAck,
  output logic busRdValid,
  output logic [31:0] busRdata,
  output logic busRdLast,
  output logic busCacheEnable,
  output logic [31:0] nRd,
  output logic [31:0] nWr,
  output logic [31:0] wrAddr,
  output logic [31:0] wrData
);
  // ==========================================================
  // Memory contents are a fixed pattern of the word address
  function automatic logic [31:0] memw(input logic [31:0] a);
    return {a[31:2], 2'b00} ^ 32'hc3a50000;
  endfunction
  // ==========================================================
  // Serve one request at a time; ack delay varies 0..2 cycles
  initial begin
    logic [31:0] a;
    logic w;
    int n;
    {busReqAck, busRdValid, busRdLast, busCacheEnable} = '0;
    {busRdata, nRd, nWr, wrAddr, wrData} = '0;
    forever begin
      @(posedge clk_sys);
      // Idle data lines toggle so stale data never looks valid
      busRdata <= ~busRdata;
      if (!reset && busReqValid === 1'b1) begin
        a = busReqAddr;
        w = busReqWrite;
        n = busReqLine ? 4 : 1;
        repeat ((nRd + nWr) % 3) @(posedge clk_sys);
        busReqAck <= 1'b1;
        if (w) begin
          nWr = nWr + 1;
          wrAddr = a;
          wrData = busWdata;
        end
        @(posedge clk_sys);
        busReqAck <= 1'b0;
        if (!w) begin
          nRd = nRd + 1;
          // Ascending beats; cache enable offered with every beat
          for (int i = 0; i < n; i++) begin
            busRdValid <= 1'b1;
            busRdata <= memw(a + 32'(4 * i));
            busRdLast <= (i == n - 1);
            busCacheEnable <= kenIn;
            @(posedge clk_sys);
          end
          busRdValid <= 1'b0;
          busRdLast <= 1'b0;
          busCacheEnable <= 1'b0;
          busRdata <= ~busRdata;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the four-way cache
`timescale 1ns/100ps
`default_nettype none
`include "fwdc_defines.svh"
module testbench;
  // ==========================================================
  // Design and model signals
  logic clk_sys, reset, clkEn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, reqAddr, reqWdata, respRdata, busReqAddr, busWdata, busRdata, invAddr;
  logic [3:0] reqByteEn, busByteEn;
  logic reqValid, reqWrite, reqPageCacheable, reqIo, reqReady, respValid, invValid, kenIn;
  logic busReqValid, busReqWrite, busReqLine, busReqAck, busRdValid, busRdLast, busCacheEnable;
  logic [31:0] nRd, nWr, wrAddr, wrData, q, rdat, L;
  logic e;
  int n_errors, samples_checked, lat;
  fwdc_cache u_fwdc_cache (.*);
  fwdc_bus_model u_fwdc_bus_model (.*);
  // ==========================================================
  // Clock, watchdog and verdict
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    test_done;
  end
  task automatic test_done;
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ==========================================================
  // Address and memory helpers
  function automatic logic [31:0] ad(input logic [19:0] t, input logic [7:0] i, input logic [3:0] o);
    return {t, i, o};
  endfunction
  function automatic logic [31:0] memw(input logic [31:0] a);
    return {a[31:2], 2'b00} ^ 32'hc3a50000;
  endfunction
  // ==========================================================
  // Bus tasks: always entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Lookup; lat counts edges from acceptance to the answer
  task automatic look(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqAddr <= a;
    reqWdata <= d;
    reqByteEn <= be;
    do @(posedge clk_sys); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    lat = 0;
    do begin
      @(posedge clk_sys);
      lat++;
    end while (respValid !== 1'b1 && lat < 400);
    if (respValid !== 1'b1) n_errors++;
    rdat = respRdata;
    @(posedge clk_sys);
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] x, input logic [31:0] r);
    logic [31:0] n0;
    n0 = nRd;
    look(1'b0, a, 32'h0, 4'hf);
    chk(rdat, x);
    chk(nRd - n0, r);
  endtask
  task automatic wrchk(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be, input logic [31:0] r);
    logic [31:0] w0;
    w0 = nWr;
    look(1'b1, a, d, be);
    chk(nWr - w0, r);
    if (r != 0) begin
      chk(wrAddr, a);
      chk(wrData, d);
    end
  endtask
  task automatic inv(input logic [31:0] a);
    invValid <= 1'b1;
    invAddr <= a;
    @(posedge clk_sys);
    invValid <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  // ==========================================================
  // Scenarios
  task automatic s_reset;
    chk(reqReady, 1'b1);
    apb(1'b0, `FWDC_OFS_MCW, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, `FWDC_OFS_STATUS, 32'hffffffff);
    apb(1'b0, `FWDC_OFS_STATUS, 32'h0);
    chk(q, 32'h2);
    apb(1'b0, `FWDC_OFS_MISSES, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(e, 1'b1);
  endtask
  task automatic s_fill;
    apb(1'b1, `FWDC_OFS_MCW, 32'h3);
    rdchk(ad(1, 5, 8), memw(ad(1, 5, 8)), 1);
    rdchk(ad(1, 5, 12), memw(ad(1, 5, 12)), 0);
    chk(lat, 1);
    // Three more tags of the same set take the other ways
    for (int t = 2; t < 5; t++) rdchk(ad(20'(t), 5, 0), memw(ad(20'(t), 5, 0)), 1);
    for (int t = 1; t < 5; t++) rdchk(ad(20'(t), 5, 4), memw(ad(20'(t), 5, 4)), 0);
    rdchk(ad(5, 5, 0), memw(ad(5, 5, 0)), 1);
    rdchk(ad(5, 5, 4), memw(ad(5, 5, 4)), 0);
    rdchk(ad(1, 5, 4), memw(ad(1, 5, 4)), 1);
    rdchk(ad(2, 5, 4), memw(ad(2, 5, 4)), 0);
  endtask
  task automatic s_write;
    logic [31:0] w0;
    wrchk(ad(5, 5, 0), 32'h1234abcd, 4'h3, 1);
    rdchk(ad(5, 5, 0), (memw(ad(5, 5, 0)) & 32'hffff0000) | 32'h0000abcd, 0);
    wrchk(ad(9, 7, 0), 32'h55, 4'hf, 1);
    rdchk(ad(9, 7, 0), memw(ad(9, 7, 0)), 1);
    apb(1'b1, `FWDC_OFS_MCW, 32'h7);
    wrchk(ad(5, 5, 0), 32'h600d0001, 4'hf, 0);
    rdchk(ad(5, 5, 0), 32'h600d0001, 0);
    // Ways 1 and 3 touched: dirty way 0 is the victim
    rdchk(ad(2, 5, 4), memw(ad(2, 5, 4)), 0);
    rdchk(ad(4, 5, 4), memw(ad(4, 5, 4)), 0);
    w0 = nWr;
    rdchk(ad(6, 5, 0), memw(ad(6, 5, 0)), 1);
    chk(nWr - w0, 32'h4);
    chk(wrAddr, ad(5, 5, 12));
    chk(wrData, memw(ad(5, 5, 12)));
    wrchk(ad(6, 5, 0), 32'h600d0002, 4'hf, 0);
  endtask
  // I/O, page not cacheable, external enable low: never allocated
  task automatic s_nocache;
    apb(1'b1, `FWDC_OFS_MCW, 32'h3);
    for (int k = 0; k < 3; k++) begin
      reqIo <= (k == 0);
      reqPageCacheable <= (k != 1);
      kenIn <= (k != 2);
      repeat (2) rdchk(ad(6, 8'(9 + k), 4), memw(ad(6, 8'(9 + k), 4)), 1);
    end
    reqIo <= 1'b0;
    reqPageCacheable <= 1'b1;
    kenIn <= 1'b1;
    L = ad(6, 9, 0);
    rdchk(L, memw(L), 1);
  endtask
  task automatic s_modes;
    apb(1'b1, `FWDC_OFS_MCW, 32'h2);
    rdchk(L, memw(L), 0);
    repeat (2) rdchk(ad(7, 9, 0), memw(ad(7, 9, 0)), 1);
    wrchk(L, 32'h0a0b0c0d, 4'hf, 1);
    inv(L);
    rdchk(L, memw(L), 1);
    apb(1'b1, `FWDC_OFS_MCW, 32'h3);
    rdchk(L, memw(L), 1);
    apb(1'b1, `FWDC_OFS_MCW, 32'h0);
    wrchk(L, 32'h77, 4'hf, 0);
    wrchk(ad(8, 9, 0), 32'h88, 4'hf, 1);
    inv(L);
    rdchk(L, 32'h77, 0);
  endtask
  // Flush also discards the dirty line of set 5 without write-out
  task automatic s_flush;
    apb(1'b1, `FWDC_OFS_MCW, 32'hb);
    apb(1'b0, `FWDC_OFS_MCW, 32'h0);
    chk(q, 32'h3);
    rdchk(L, memw(L), 1);
    rdchk(ad(6, 5, 0), memw(ad(6, 5, 0)), 1);
    // Mid-run reset clears the lines just filled
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rdchk(L, memw(L), 1);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {reset, clkEn, reqPageCacheable, kenIn} = 4'hf;
    {psel, penable, pwrite, reqValid, reqWrite, reqIo, invValid} = '0;
    {paddr, pwdata, reqAddr, reqWdata, invAddr} = '0;
    reqByteEn = 4'hf;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    s_reset;
    s_fill;
    s_write;
    s_nocache;
    s_modes;
    s_flush;
    test_done;
  end
endmodule
`default_nettype wire
